/* core/csdf_card_end.sv */
// Purpose: card end holding the later card record fields
// Assumes: host keeps to one request per answer
// Notes: fixed fields are constants; programmable ones persist via image
// What this block does
// - low-volt current codes fixed at 5
// - high-volt current codes fixed at 5
// - capacity multiplier code 4, factor 64
// - sector size 0, one 512-byte block
// - erase group 15, sixteen sectors
// - protect group 1, two erase groups
// - group protection reported available
// - recommended ECC reported as none
// - write speed factor 2, 6-7 reserved
// - write block length code 9, 512 bytes
// - no partial flag means exact length
// - partial flag 0, short writes refused
// - copy flag set once, stays set
// - permanent protect once, blocks writes/erases
// - temporary protect reprogrammable, blocks writes/erases
// - format group 0 codes 0-3, group 1 reserved
// - format fields read-only on ROM cards
// - host picks decoding from ECC type
// - ECC type 0 none, 1 BCH, rest reserved
`timescale 1ns/1ps
module csdf_card_end #(
   parameter bit ROM_CARD = 1'b0
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_ce,
   csdf_link_if.dev                       link,
   input  wire logic                      i_nv_load,
   input  wire logic [csdf_pkg::NV_W-1:0] i_nv_image,
   output logic [csdf_pkg::NV_W-1:0]      o_nv_image,
   output logic [11:0]                    o_blk_len,
   output logic                           o_write_go,
   output logic                           o_erase_go,
   output logic                           o_protected
);
   if (csdf_pkg::DATA_W < 12) begin : g_chk
      $error("csdf_card_end: data width too small for block length");
   end

   logic        copy_q;
   logic        perm_q;
   logic        temp_q;
   logic [0:0]  fgrp_q;
   logic [1:0]  fmt_q;
   logic [3:0]  ecc_q;
   logic        copy_lock;
   logic        perm_lock;
   logic [11:0] blk_len;
   logic        next_rsp_valid;
   logic [1:0]  next_rsp_err;
   logic [11:0] next_rsp_data;

   // request decode
   wire [4:0]  idx      = link.req_idx;
   wire [11:0] arg      = link.req_data;
   wire        is_read  = link.req_valid && link.req_op == csdf_pkg::OP_READ;
   wire        is_prog  = link.req_valid && link.req_op == csdf_pkg::OP_PROG;
   wire        is_len   = link.req_valid && link.req_op == csdf_pkg::OP_SET_BLKLEN;
   wire        is_write = link.req_valid && link.req_op == csdf_pkg::OP_WRITE;
   wire        is_erase = link.req_valid && link.req_op == csdf_pkg::OP_ERASE;
   wire        protect  = perm_q || temp_q;

   // full write block from the fixed length code
   wire [11:0] full_len = 12'h001 << csdf_pkg::VAL_WR_BLK_LEN;

   // field readback, fixed fields as constants
   wire [11:0] rd_val =
      (idx == csdf_pkg::FLD_RD_CUR_LOW)  ? 12'(csdf_pkg::VAL_CUR_LOW) :
      (idx == csdf_pkg::FLD_WR_CUR_LOW)  ? 12'(csdf_pkg::VAL_CUR_LOW) :
      (idx == csdf_pkg::FLD_RD_CUR_HIGH) ? 12'(csdf_pkg::VAL_CUR_HIGH) :
      (idx == csdf_pkg::FLD_WR_CUR_HIGH) ? 12'(csdf_pkg::VAL_CUR_HIGH) :
      (idx == csdf_pkg::FLD_CAP_MULT)    ? 12'(csdf_pkg::VAL_CAP_MULT) :
      (idx == csdf_pkg::FLD_SECTOR)      ? 12'(csdf_pkg::VAL_SECTOR) :
      (idx == csdf_pkg::FLD_ERASE_GRP)   ? 12'(csdf_pkg::VAL_ERASE_GRP) :
      (idx == csdf_pkg::FLD_PROT_GRP)    ? 12'(csdf_pkg::VAL_PROT_GRP) :
      (idx == csdf_pkg::FLD_GRP_PROT)    ? 12'(csdf_pkg::VAL_GRP_PROT) :
      (idx == csdf_pkg::FLD_DEF_ECC)     ? 12'(csdf_pkg::VAL_DEF_ECC) :
      (idx == csdf_pkg::FLD_WR_SPEED)    ? 12'(csdf_pkg::VAL_WR_SPEED) :
      (idx == csdf_pkg::FLD_WR_BLK_LEN)  ? 12'(csdf_pkg::VAL_WR_BLK_LEN) :
      (idx == csdf_pkg::FLD_PARTIAL)     ? 12'(csdf_pkg::VAL_PARTIAL) :
      (idx == csdf_pkg::FLD_FMT_GRP)     ? 12'(fgrp_q) :
      (idx == csdf_pkg::FLD_COPY)        ? 12'(copy_q) :
      (idx == csdf_pkg::FLD_PERM)        ? 12'(perm_q) :
      (idx == csdf_pkg::FLD_TEMP)        ? 12'(temp_q) :
      (idx == csdf_pkg::FLD_FMT)         ? 12'(fmt_q) :
      (idx == csdf_pkg::FLD_ECC)         ? 12'(ecc_q) : 12'h000;
   wire        rd_bad = idx > csdf_pkg::FLD_ECC;

   // programming legality per field; fixed fields never take a value
   wire bad_fgrp = ROM_CARD || arg != 12'(csdf_pkg::RST_FMT_GRP);
   wire bad_fmt  = ROM_CARD || arg > 12'(csdf_pkg::FMT_MAX);
   wire bad_ecc  = arg > 12'(csdf_pkg::ECC_BCH);
   wire bad_copy = arg > 12'h001 || (copy_lock && arg == 12'h000);
   wire bad_perm = arg > 12'h001 || (perm_lock && arg == 12'h000);
   wire bad_temp = arg > 12'h001;
   wire prog_bad =
      (idx == csdf_pkg::FLD_FMT_GRP) ? bad_fgrp :
      (idx == csdf_pkg::FLD_COPY)    ? bad_copy :
      (idx == csdf_pkg::FLD_PERM)    ? bad_perm :
      (idx == csdf_pkg::FLD_TEMP)    ? bad_temp :
      (idx == csdf_pkg::FLD_FMT)     ? bad_fmt :
      (idx == csdf_pkg::FLD_ECC)     ? bad_ecc : 1'b1;
   wire prog_ok  = is_prog && !prog_bad;

   // block length command accepts 1 up to the largest block
   wire len_bad   = arg == 12'h000 || arg > csdf_pkg::BLK_LEN_MAX;
   // writes take exactly the full block; no partial writes
   wire write_bad = blk_len != full_len;
   wire write_ok  = is_write && !protect && !write_bad;
   wire erase_ok  = is_erase && !protect;

   // answer code for the request in hand
   assign next_rsp_err =
      is_read  ? (rd_bad ? csdf_pkg::ERR_FIELD : csdf_pkg::ERR_NONE) :
      is_prog  ? (prog_bad ? csdf_pkg::ERR_FIELD : csdf_pkg::ERR_NONE) :
      is_len   ? (len_bad ? csdf_pkg::ERR_LENGTH : csdf_pkg::ERR_NONE) :
      is_write ? (protect ? csdf_pkg::ERR_PROTECT :
                  write_bad ? csdf_pkg::ERR_LENGTH : csdf_pkg::ERR_NONE) :
      is_erase ? (protect ? csdf_pkg::ERR_PROTECT : csdf_pkg::ERR_NONE) :
                 csdf_pkg::ERR_FIELD;
   assign next_rsp_data  = is_read ? rd_val : (is_len ? arg : blk_len);
   assign next_rsp_valid = link.req_valid;

   // persistent programmable fields
   csdf_nv_cell #(.W(1), .ONCE(1'b1), .RST_V(csdf_pkg::RST_FLAG)) u_copy (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_load     (i_nv_load),
      .i_load_val (i_nv_image[csdf_pkg::NV_COPY]),
      .i_prog     (prog_ok && idx == csdf_pkg::FLD_COPY),
      .i_prog_val (arg[0]),
      .o_q        (copy_q),
      .o_locked   (copy_lock)
   );
   csdf_nv_cell #(.W(1), .ONCE(1'b1), .RST_V(csdf_pkg::RST_FLAG)) u_perm (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_load     (i_nv_load),
      .i_load_val (i_nv_image[csdf_pkg::NV_PERM]),
      .i_prog     (prog_ok && idx == csdf_pkg::FLD_PERM),
      .i_prog_val (arg[0]),
      .o_q        (perm_q),
      .o_locked   (perm_lock)
   );
   csdf_nv_cell #(.W(1), .ONCE(1'b0), .RST_V(csdf_pkg::RST_FLAG)) u_temp (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_load     (i_nv_load),
      .i_load_val (i_nv_image[csdf_pkg::NV_TEMP]),
      .i_prog     (prog_ok && idx == csdf_pkg::FLD_TEMP),
      .i_prog_val (arg[0]),
      .o_q        (temp_q),
      .o_locked   ()
   );
   csdf_nv_cell #(.W(1), .ONCE(1'b0), .RST_V(csdf_pkg::RST_FMT_GRP)) u_fgrp (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_load     (i_nv_load),
      .i_load_val (i_nv_image[csdf_pkg::NV_FGRP +: 1]),
      .i_prog     (prog_ok && idx == csdf_pkg::FLD_FMT_GRP),
      .i_prog_val (arg[0:0]),
      .o_q        (fgrp_q),
      .o_locked   ()
   );
   csdf_nv_cell #(.W(2), .ONCE(1'b0), .RST_V(csdf_pkg::RST_FMT)) u_fmt (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_load     (i_nv_load),
      .i_load_val (i_nv_image[csdf_pkg::NV_FMT +: 2]),
      .i_prog     (prog_ok && idx == csdf_pkg::FLD_FMT),
      .i_prog_val (arg[1:0]),
      .o_q        (fmt_q),
      .o_locked   ()
   );
   csdf_nv_cell #(.W(4), .ONCE(1'b0), .RST_V(csdf_pkg::RST_ECC)) u_ecc (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_load     (i_nv_load),
      .i_load_val (i_nv_image[csdf_pkg::NV_ECC +: 4]),
      .i_prog     (prog_ok && idx == csdf_pkg::FLD_ECC),
      .i_prog_val (arg[3:0]),
      .o_q        (ecc_q),
      .o_locked   ()
   );

   // image for the external persistent store, all cell flops
   assign o_nv_image = {ecc_q, fmt_q, fgrp_q, temp_q, perm_q, copy_q};
   assign o_blk_len  = blk_len;

   // working block length
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         blk_len <= csdf_pkg::RST_BLK_LEN;
      end else if (i_ce && is_len && !len_bad) begin
         blk_len <= arg;
      end
   end

   // answer and action strobes
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         link.rsp_valid <= 1'b0;
         link.rsp_err   <= csdf_pkg::ERR_NONE;
         link.rsp_data  <= 12'h000;
         o_write_go     <= 1'b0;
         o_erase_go     <= 1'b0;
         o_protected    <= 1'b0;
      end else if (i_ce) begin
         link.rsp_valid <= next_rsp_valid;
         link.rsp_err   <= next_rsp_err;
         link.rsp_data  <= next_rsp_data;
         o_write_go     <= write_ok;
         o_erase_go     <= erase_ok;
         o_protected    <= protect;
      end
   end
endmodule : csdf_card_end

/* core/csdf_host_end.sv */
// Purpose: host end that reads and programs the card record
// Assumes: software port strobes are one cycle and never overlap
// Notes: caches decode-relevant fields from successful reads
`timescale 1ns/1ps
module csdf_host_end (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   csdf_link_if.host        link,
   input  wire logic [2:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   output logic [1:0]       o_ecc_mode
);
   typedef enum logic {ST_IDLE, ST_WAIT} csdf_hst_e;

   csdf_hst_e   state;
   logic [11:0] arg;
   logic [11:0] result;
   logic [1:0]  err;
   logic        done;
   logic [4:0]  pend_idx;
   csdf_pkg::csdf_op_e pend_op;
   logic [11:0] cur_len;
   logic        part_c;
   logic [3:0]  wbl_c;
   logic [2:0]  cap_c;
   logic        fgrp_c;
   logic [1:0]  fmt_c;

   // command decode
   wire        cmd_wr   = i_ce && i_wr && i_addr == csdf_pkg::REG_CMD && state == ST_IDLE;
   wire [2:0]  cmd_code = i_wdata[7:5];
   wire        op_ok    = cmd_code <= 3'(csdf_pkg::OP_ERASE);
   wire [11:0] full_len = 12'h001 << wbl_c;
   // refuse locally a write whose size the card cannot take
   wire        len_bad  = cmd_code == 3'(csdf_pkg::OP_WRITE) && !part_c
                          && cur_len != full_len;
   wire        launch   = cmd_wr && op_ok && !len_bad;
   wire        rsp_ok   = state == ST_WAIT && link.rsp_valid
                          && link.rsp_err == csdf_pkg::ERR_NONE;
   wire        rd_hit   = rsp_ok && pend_op == csdf_pkg::OP_READ;

   // decode selection from the stored ECC type
   wire [1:0]  next_ecc_mode =
      (link.rsp_data[3:0] == csdf_pkg::RST_ECC) ? csdf_pkg::DEC_NONE :
      (link.rsp_data[3:0] == csdf_pkg::ECC_BCH) ? csdf_pkg::DEC_BCH :
                                                   csdf_pkg::DEC_RSVD;
   // multiplier factor from the capacity code
   wire [9:0]  mult     = 10'h001 << (4'(cap_c) + 4'(csdf_pkg::MULT_OFFSET));
   wire        fmt_known = fgrp_c == csdf_pkg::RST_FMT_GRP;
   wire [15:0] info     = {11'h000, fmt_known, fmt_c, o_ecc_mode};
   wire [15:0] status   = {12'h000, err, done, state == ST_WAIT};
   wire [15:0] rd_mux   =
      (i_addr == csdf_pkg::REG_ARG)    ? {4'h0, arg} :
      (i_addr == csdf_pkg::REG_STATUS) ? status :
      (i_addr == csdf_pkg::REG_RESULT) ? {4'h0, result} :
      (i_addr == csdf_pkg::REG_INFO)   ? info :
      (i_addr == csdf_pkg::REG_MULT)   ? {6'h00, mult} : 16'h0000;

   // command launch, answer capture and status
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state          <= ST_IDLE;
         link.req_valid <= 1'b0;
         link.req_op    <= csdf_pkg::OP_READ;
         link.req_idx   <= 5'h00;
         link.req_data  <= 12'h000;
         pend_op        <= csdf_pkg::OP_READ;
         pend_idx       <= 5'h00;
         arg            <= 12'h000;
         result         <= 12'h000;
         err            <= csdf_pkg::ERR_NONE;
         done           <= 1'b0;
      end else if (i_ce) begin
         link.req_valid <= launch;
         if (i_wr && i_addr == csdf_pkg::REG_ARG) begin
            arg <= i_wdata[11:0];
         end
         if (launch) begin
            state         <= ST_WAIT;
            link.req_op   <= csdf_pkg::csdf_op_e'(cmd_code);
            link.req_idx  <= i_wdata[4:0];
            link.req_data <= arg;
            pend_op       <= csdf_pkg::csdf_op_e'(cmd_code);
            pend_idx      <= i_wdata[4:0];
            done          <= 1'b0;
         end else if (cmd_wr) begin
            done <= 1'b1;
            err  <= op_ok ? csdf_pkg::ERR_LENGTH : csdf_pkg::ERR_FIELD;
         end else if (state == ST_WAIT && link.rsp_valid) begin
            state  <= ST_IDLE;
            result <= link.rsp_data;
            err    <= link.rsp_err;
            done   <= 1'b1;
         end
      end
   end

   // cached card fields, defaults as the card resets
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cur_len    <= csdf_pkg::RST_BLK_LEN;
         part_c     <= csdf_pkg::VAL_PARTIAL;
         wbl_c      <= csdf_pkg::VAL_WR_BLK_LEN;
         cap_c      <= csdf_pkg::VAL_CAP_MULT;
         fgrp_c     <= csdf_pkg::RST_FMT_GRP;
         fmt_c      <= csdf_pkg::RST_FMT;
         o_ecc_mode <= csdf_pkg::DEC_NONE;
         o_rdata    <= 16'h0000;
      end else if (i_ce) begin
         o_rdata <= i_rd ? rd_mux : 16'h0000;
         if (rsp_ok && pend_op == csdf_pkg::OP_SET_BLKLEN) begin
            cur_len <= link.rsp_data;
         end
         if (rd_hit && pend_idx == csdf_pkg::FLD_PARTIAL) begin
            part_c <= link.rsp_data[0];
         end
         if (rd_hit && pend_idx == csdf_pkg::FLD_WR_BLK_LEN) begin
            wbl_c <= link.rsp_data[3:0];
         end
         if (rd_hit && pend_idx == csdf_pkg::FLD_CAP_MULT) begin
            cap_c <= link.rsp_data[2:0];
         end
         if (rd_hit && pend_idx == csdf_pkg::FLD_FMT_GRP) begin
            fgrp_c <= link.rsp_data[0];
         end
         if (rd_hit && pend_idx == csdf_pkg::FLD_FMT) begin
            fmt_c <= link.rsp_data[1:0];
         end
         if (rd_hit && pend_idx == csdf_pkg::FLD_ECC) begin
            o_ecc_mode <= next_ecc_mode;
         end
      end
   end
endmodule : csdf_host_end

/* core/csdf_link_if.sv */
// Purpose: request and answer link between host and card record
// Assumes: both ends on the same clock and clock enable
// Notes: one request in flight; answer one enabled cycle later
`timescale 1ns/1ps
interface csdf_link_if;
   logic                              req_valid;
   csdf_pkg::csdf_op_e                req_op;
   logic [csdf_pkg::IDX_W-1:0]        req_idx;
   logic [csdf_pkg::DATA_W-1:0]       req_data;
   logic                              rsp_valid;
   logic [1:0]                        rsp_err;
   logic [csdf_pkg::DATA_W-1:0]       rsp_data;

   modport dev (
      input  req_valid, req_op, req_idx, req_data,
      output rsp_valid, rsp_err, rsp_data
   );
   modport host (
      output req_valid, req_op, req_idx, req_data,
      input  rsp_valid, rsp_err, rsp_data
   );
endinterface : csdf_link_if

/* core/csdf_nv_cell.sv */
// Purpose: one persistent programmable field of the card record
// Assumes: restore strobe carries the saved image after power-up
// Notes: programming only ever moves a one-time cell from clear to set; reset loads RST_V and restore loads any value
`timescale 1ns/1ps
module csdf_nv_cell #(
   parameter int           W     = 1,
   parameter bit           ONCE  = 1'b0,
   parameter logic [W-1:0] RST_V = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_ce,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_load_val,
   input  wire logic         i_prog,
   input  wire logic [W-1:0] i_prog_val,
   output logic [W-1:0]      o_q,
   output logic              o_locked
);
   if (W < 1 || (ONCE && W != 1)) begin : g_chk
      $error("csdf_nv_cell: one-time cells must be one bit wide");
   end

   // a set one-time bit refuses any further programming
   assign o_locked = ONCE && o_q[0];

   // restore wins over programming in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_q <= RST_V;
      end else if (i_ce) begin
         if (i_load) begin
            o_q <= i_load_val;
         end else if (i_prog && !o_locked) begin
            o_q <= i_prog_val;
         end
      end
   end
endmodule : csdf_nv_cell

/* core/csdf_pkg.sv */
// Purpose: shared constants for the card record fields and the link
// Assumes: one clock shared by both ends
// Notes: field values and link codes are defined only here
package csdf_pkg;
   localparam int IDX_W  = 5;
   localparam int DATA_W = 12;
   localparam int NV_W   = 10;

   // link operations
   typedef enum logic [2:0] {
      OP_READ, OP_PROG, OP_SET_BLKLEN, OP_WRITE, OP_ERASE
   } csdf_op_e;

   // answer codes
   localparam logic [1:0] ERR_NONE    = 2'h0;
   localparam logic [1:0] ERR_PROTECT = 2'h1;
   localparam logic [1:0] ERR_LENGTH  = 2'h2;
   localparam logic [1:0] ERR_FIELD   = 2'h3;

   // field indices
   localparam logic [4:0] FLD_RD_CUR_LOW  = 5'h00;
   localparam logic [4:0] FLD_WR_CUR_LOW  = 5'h01;
   localparam logic [4:0] FLD_RD_CUR_HIGH = 5'h02;
   localparam logic [4:0] FLD_WR_CUR_HIGH = 5'h03;
   localparam logic [4:0] FLD_CAP_MULT    = 5'h04;
   localparam logic [4:0] FLD_SECTOR      = 5'h05;
   localparam logic [4:0] FLD_ERASE_GRP   = 5'h06;
   localparam logic [4:0] FLD_PROT_GRP    = 5'h07;
   localparam logic [4:0] FLD_GRP_PROT    = 5'h08;
   localparam logic [4:0] FLD_DEF_ECC     = 5'h09;
   localparam logic [4:0] FLD_WR_SPEED    = 5'h0A;
   localparam logic [4:0] FLD_WR_BLK_LEN  = 5'h0B;
   localparam logic [4:0] FLD_PARTIAL     = 5'h0C;
   localparam logic [4:0] FLD_FMT_GRP     = 5'h0D;
   localparam logic [4:0] FLD_COPY        = 5'h0E;
   localparam logic [4:0] FLD_PERM        = 5'h0F;
   localparam logic [4:0] FLD_TEMP        = 5'h10;
   localparam logic [4:0] FLD_FMT         = 5'h11;
   localparam logic [4:0] FLD_ECC         = 5'h12;

   // fixed field values
   localparam logic [2:0] VAL_CUR_LOW    = 3'h5;
   localparam logic [2:0] VAL_CUR_HIGH   = 3'h5;
   localparam logic [2:0] VAL_CAP_MULT   = 3'h4;
   localparam logic [4:0] VAL_SECTOR     = 5'h00;
   localparam logic [4:0] VAL_ERASE_GRP  = 5'h0F;
   localparam logic [4:0] VAL_PROT_GRP   = 5'h01;
   localparam logic [0:0] VAL_GRP_PROT   = 1'h1;
   localparam logic [1:0] VAL_DEF_ECC    = 2'h0;
   localparam logic [2:0] VAL_WR_SPEED   = 3'h2;
   localparam logic [3:0] VAL_WR_BLK_LEN = 4'h9;
   localparam logic [0:0] VAL_PARTIAL    = 1'h0;

   // programmable field defaults and limits
   localparam logic [0:0] RST_FLAG      = 1'h0;
   localparam logic [0:0] RST_FMT_GRP   = 1'h0;
   localparam logic [1:0] RST_FMT       = 2'h0;
   localparam logic [3:0] RST_ECC       = 4'h0;
   localparam logic [3:0] ECC_BCH       = 4'h1;
   localparam logic [1:0] FMT_MAX       = 2'h3;
   localparam logic [1:0] MULT_OFFSET   = 2'h2;
   localparam logic [11:0] BLK_LEN_MAX  = 12'h800;
   localparam logic [11:0] RST_BLK_LEN  = 12'h200;

   // persistent image bit positions
   localparam int NV_COPY = 0;
   localparam int NV_PERM = 1;
   localparam int NV_TEMP = 2;
   localparam int NV_FGRP = 3;
   localparam int NV_FMT  = 4;
   localparam int NV_ECC  = 6;

   // host register map
   localparam logic [2:0] REG_CMD    = 3'h0;
   localparam logic [2:0] REG_ARG    = 3'h1;
   localparam logic [2:0] REG_STATUS = 3'h2;
   localparam logic [2:0] REG_RESULT = 3'h3;
   localparam logic [2:0] REG_INFO   = 3'h4;
   localparam logic [2:0] REG_MULT   = 3'h5;

   // host decode modes
   localparam logic [1:0] DEC_NONE = 2'h0;
   localparam logic [1:0] DEC_BCH  = 2'h1;
   localparam logic [1:0] DEC_RSVD = 2'h2;
endpackage : csdf_pkg

/* test/csdf_properties.sv */
// Purpose: link checks between host end and card end
// Assumes: clock enable held high throughout
// Notes: each answer is judged one cycle after its request
`timescale 1ns/1ps
module csdf_properties (
   input wire logic                        i_clk,
   input wire logic                        i_rst_n,
   input wire logic                        req_valid,
   input wire csdf_pkg::csdf_op_e          req_op,
   input wire logic [csdf_pkg::IDX_W-1:0]  req_idx,
   input wire logic [csdf_pkg::DATA_W-1:0] req_data,
   input wire logic                        rsp_valid,
   input wire logic [1:0]                  rsp_err,
   input wire logic [csdf_pkg::DATA_W-1:0] rsp_data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // read and program request decodes
   wire rd = req_valid && (req_op == csdf_pkg::OP_READ);
   wire pg = req_valid && (req_op == csdf_pkg::OP_PROG);
   answer_follows_a: assert property (req_valid |=> rsp_valid)
      else $error("no answer after request");
   answer_caused_a: assert property (rsp_valid |-> $past(req_valid))
      else $error("answer without request");
   cur_low_code_a: assert property (
      rd && req_idx == csdf_pkg::FLD_RD_CUR_LOW |=> rsp_data == 12'h005) else $error("bad cur");
   cap_mult_code_a: assert property (
      rd && req_idx == csdf_pkg::FLD_CAP_MULT |=> rsp_data == 12'h004) else $error("bad mult");
   blk_len_code_a: assert property (
      rd && req_idx == csdf_pkg::FLD_WR_BLK_LEN |=> rsp_data == 12'h009) else $error("bad len");
   no_partial_a: assert property (
      rd && req_idx == csdf_pkg::FLD_PARTIAL |=> rsp_data == 12'h000) else $error("bad part");
   fmt_group_a: assert property (
      pg && req_idx == csdf_pkg::FLD_FMT_GRP && req_data != 12'h000 |=> rsp_err == 2'h3)
      else $error("group accepted");
   ecc_range_a: assert property (
      pg && req_idx == csdf_pkg::FLD_ECC && req_data > 12'h001 |=> rsp_err == 2'h3)
      else $error("ecc accepted");
   fixed_fields_a: assert property (
      pg && req_idx <= csdf_pkg::FLD_PARTIAL |=> rsp_err == 2'h3) else $error("fixed changed");
endmodule : csdf_properties

/* test/testbench.sv */
// Purpose: drives both ends through the software port
// Assumes: clock enable held high
// Notes: each scenario judges its own answers
`timescale 1ns/1ps
module testbench;
   logic        i_clk = 0;
   logic        i_rst_n = 0;
   logic [2:0]  i_addr = '0;
   logic [15:0] i_wdata = '0;
   logic        i_wr = 0;
   logic        i_rd = 0;
   logic        i_nv_load = 0;
   logic [9:0]  nv_out, nv_save;
   int          n_go = 0;
   logic [15:0] o_rdata, rv;
   logic [11:0] o_blk_len;
   logic [1:0]  o_ecc_mode;
   logic        o_write_go, o_erase_go, o_protected;
   int          fail_count = 0;
   int          n_compared = 0;
   csdf_link_if link ();
   // the two ends face each other across the link
   csdf_card_end csdf_card_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .link(link),
      .i_nv_load(i_nv_load), .i_nv_image(nv_save), .o_nv_image(nv_out), .o_blk_len(o_blk_len),
      .o_write_go(o_write_go), .o_erase_go(o_erase_go), .o_protected(o_protected));
   csdf_host_end csdf_host_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .link(link),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_ecc_mode(o_ecc_mode));
   csdf_properties csdf_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .req_valid(link.req_valid),
      .req_op(link.req_op), .req_idx(link.req_idx), .req_data(link.req_data),
      .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err), .rsp_data(link.rsp_data));
   // 50 ns clock
   always #25 i_clk = ~i_clk;
   // card strobes seen
   always @(posedge i_clk) n_go += o_write_go + o_erase_go;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // one software port cycle, read data taken in the following cycle
   task automatic sw(input logic wr, input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= wr;
      i_rd <= !wr;
      @(posedge i_clk);
      i_wr <= 0;
      i_rd <= 0;
      #1 rv = o_rdata;
   endtask : sw
   // launch one link operation, wait for done, judge code and read value
   task automatic cmd(input logic [2:0] op, input logic [4:0] ix, input logic [11:0] arg,
                      input logic [1:0] err, input logic [11:0] res);
      sw(1, csdf_pkg::REG_ARG, {4'h0, arg});
      sw(1, csdf_pkg::REG_CMD, {8'h00, op, ix});
      for (int n = 0; n < 20; n++) begin
         sw(0, csdf_pkg::REG_STATUS, 16'h0000);
         if (rv[1:0] === 2'b10) break;
         if (n == 19) begin
            fail_count++;
            final_report();
         end
      end
      chk({14'h0, rv[3:2]}, {14'h0, err});
      if (op == csdf_pkg::OP_READ) begin
         sw(0, csdf_pkg::REG_RESULT, 16'h0000);
         chk(rv, {4'h0, res});
      end
   endtask : cmd
   task automatic t_fixed;
      int ex [13] = '{5, 5, 5, 5, 4, 0, 15, 1, 1, 0, 2, 9, 0};
      for (int i = 0; i < 13; i++)
         cmd(csdf_pkg::OP_READ, 5'(i), 12'h000, 2'h0, 12'(ex[i]));
      sw(0, csdf_pkg::REG_MULT, 16'h0000);
      chk(rv, 16'h0040);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_CAP_MULT, 12'h007, 2'h3, 12'h000);
      cmd(csdf_pkg::OP_READ, csdf_pkg::FLD_CAP_MULT, 12'h000, 2'h0, 12'h004);
      $display("fixed fields done");
   endtask : t_fixed
   task automatic t_prog;
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_COPY, 12'h001, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_COPY, 12'h000, 2'h3, 12'h000);
      cmd(csdf_pkg::OP_READ, csdf_pkg::FLD_COPY, 12'h000, 2'h0, 12'h001);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_FMT_GRP, 12'h001, 2'h3, 12'h000);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_FMT, 12'h003, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_READ, csdf_pkg::FLD_FMT, 12'h000, 2'h0, 12'h003);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_ECC, 12'h002, 2'h3, 12'h000);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_ECC, 12'h001, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_READ, csdf_pkg::FLD_ECC, 12'h000, 2'h0, 12'h001);
      chk({14'h0, o_ecc_mode}, 16'h0001);
      sw(0, csdf_pkg::REG_INFO, 16'h0000);
      chk(rv, 16'h001D);
      $display("programmable fields done");
   endtask : t_prog
   task automatic t_prot;
      cmd(csdf_pkg::OP_SET_BLKLEN, 5'h00, 12'h100, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_WRITE, 5'h00, 12'h000, 2'h2, 12'h000);
      cmd(csdf_pkg::OP_SET_BLKLEN, 5'h00, 12'h000, 2'h2, 12'h000);
      cmd(csdf_pkg::OP_SET_BLKLEN, 5'h00, 12'h200, 2'h0, 12'h000);
      chk({4'h0, o_blk_len}, 16'h0200);
      cmd(csdf_pkg::OP_WRITE, 5'h00, 12'h000, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_TEMP, 12'h001, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_WRITE, 5'h00, 12'h000, 2'h1, 12'h000);
      cmd(csdf_pkg::OP_ERASE, 5'h00, 12'h000, 2'h1, 12'h000);
      chk({15'h0, o_protected}, 16'h0001);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_TEMP, 12'h000, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_ERASE, 5'h00, 12'h000, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_PERM, 12'h001, 2'h0, 12'h000);
      cmd(csdf_pkg::OP_WRITE, 5'h00, 12'h000, 2'h1, 12'h000);
      cmd(csdf_pkg::OP_PROG, csdf_pkg::FLD_PERM, 12'h000, 2'h3, 12'h000);
      chk(16'(n_go), 16'h0002);
      $display("protection done");
   endtask : t_prot
   task automatic t_nv;
      chk({6'h0, nv_out}, 16'h0073);
      nv_save = nv_out;
      i_rst_n <= 0;
      @(posedge i_clk);
      i_rst_n <= 1;
      i_nv_load <= 1;
      @(posedge i_clk);
      i_nv_load <= 0;
      cmd(csdf_pkg::OP_READ, csdf_pkg::FLD_PERM, 12'h000, 2'h0, 12'h001);
      $display("restore done");
   endtask : t_nv
   // reset for 20 cycles, then the scenarios
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1;
      t_fixed();
      t_prog();
      t_prot();
      t_nv();
      final_report();
   end
endmodule : testbench
